// ### tb/vcr_host_model.sv
// Host software model driving the index and data port pair
`timescale 1ns/1ps
module vcr_host_model (
  input wire logic ref_clk, // Clock
  output logic idx_wr, // Index write strobe
  output logic idx_rd, // Index read strobe
  output logic data_wr, // Data write strobe
  output logic data_rd, // Data read strobe
  output logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata // Read data
);
  // Idle port at time zero
  initial begin
    {idx_wr, idx_rd, data_wr, data_rd} = 4'h0;
    wdata = 8'h00;
  end

  // Index goes out first, the data access follows on the next edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge ref_clk);
    idx_wr <= 1'b1;
    wdata <= idx;
    @(posedge ref_clk);
    idx_wr <= 1'b0;
    data_wr <= 1'b1;
    wdata <= val;
    @(posedge ref_clk);
    data_wr <= 1'b0;
  endtask

  // Read data is registered, so it is sampled just after the taking edge
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    @(posedge ref_clk);
    idx_wr <= 1'b1;
    wdata <= idx;
    @(posedge ref_clk);
    idx_wr <= 1'b0;
    data_rd <= 1'b1;
    @(posedge ref_clk);
    data_rd <= 1'b0;
    #1 val = rdata;
  endtask

  // Index port read back
  task automatic rd_idx(output logic [7:0] val);
    @(posedge ref_clk);
    idx_rd <= 1'b1;
    @(posedge ref_clk);
    idx_rd <= 1'b0;
    #1 val = rdata;
  endtask
endmodule // vcr_host_model

// ### tb/vcr_regs_tb.sv
// Self-checking testbench for the vertical timing and cursor registers
`timescale 1ns/1ps
module vcr_regs_tb;
  logic ref_clk = 1'b0;
  logic reset_n, clk_en, char_tick, hretrace_end, vretrace_end, cursor_out, line_double;
  logic idx_wr, idx_rd, data_wr, data_rd;
  logic [7:0] wdata, rdata, got, v;
  logic [7:0] sh [16];
  logic [15:0] char_addr, ca, screen_base, cursor_addr;
  logic [9:0] vert_total, vsync_start, vde_end, vblank_start, line_cmp_hi;
  logic [4:0] pan_pixels, row_scan, m;
  vcr_pkg::vcr_pan_t byte_pan;
  int mismatches = 0;
  int total_checks = 0;
  int seed_ret;
  vcr_regs #(.SKEW_DEPTH(3)) vcr_regs_i (.ref_clk, .reset_n, .clk_en, .idx_wr, .idx_rd,
    .data_wr, .data_rd, .wdata, .rdata, .char_tick, .hretrace_end, .vretrace_end, .char_addr,
    .vert_total, .vsync_start, .vde_end, .vblank_start, .line_cmp_hi, .line_double, .byte_pan,
    .pan_pixels, .row_scan, .screen_base, .cursor_addr, .cursor_out);
  vcr_host_model vcr_host_model_i (.ref_clk, .idx_wr, .idx_rd, .data_wr, .data_rd, .wdata,
    .rdata);

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, g, e);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reserved bits read as zero
  function automatic logic [7:0] rd_mask(input int i);
    case (i)
      8, 11: return 8'h7f;
      10: return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction

  task automatic put(input logic [7:0] i, input logic [7:0] d);
    vcr_host_model_i.wr(i, d);
    sh[i[3:0]] = d;
  endtask

  // One-cycle strobe on vertical retrace, horizontal retrace or character tick
  task automatic pulse(input logic [2:0] w);
    @(posedge ref_clk);
    {vretrace_end, hretrace_end, char_tick} <= w;
    @(posedge ref_clk);
    {vretrace_end, hretrace_end, char_tick} <= 3'b000;
    #1;
  endtask

  task automatic row_test(input logic [4:0] p, input logic [4:0] mx, input int n);
    logic [4:0] e;
    put(8'h08, {3'b000, p});
    put(8'h09, {3'b000, mx});
    pulse(3'b100);
    chk(row_scan, p, "row preset");
    e = p;
    repeat (n) begin
      pulse(3'b010);
      e = (e == mx) ? 5'h00 : e + 5'h01;
      chk(row_scan, e, "row step");
    end
  endtask

  task automatic cur(input logic [7:0] cs, input logic [4:0] ce, input logic [4:0] r,
                     input logic h);
    put(8'h0a, cs);
    put(8'h0b, {3'b000, ce});
    row_test(r, 5'h1f, 0);
    @(posedge ref_clk);
    char_addr <= h ? ca : ~ca;
    @(posedge ref_clk);
    #1;
    chk(cursor_out, !cs[5] && cs[4:0] <= r && r <= ce && h, "cursor");
  endtask

  // Main sequence: registers, row counter, cursor window, cursor skew
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    {vretrace_end, hretrace_end, char_tick} = 3'b000;
    char_addr = 16'h0000;
    seed_ret = $urandom(32'h0000_d87a);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk({screen_base, cursor_addr}, 32'h0000_0000, "reset");
    for (int r = 0; r < 4; r++) begin
      for (int i = 6; i < 16; i++) begin
        v = (r == 0) ? 8'hff : 8'($urandom);
        if (i == 8) v = {v[7], r[1:0], v[4:0]};
        put(8'(i), v);
        vcr_host_model_i.rd(8'(i), got);
        chk(got, v & rd_mask(i), "read back");
      end
      chk(vert_total, {sh[7][5], sh[7][0], sh[6]}, "total");
      chk(vsync_start, {sh[7][7], sh[7][2], 8'h00}, "sync");
      chk(vde_end, {sh[7][6], sh[7][1], 8'h00}, "disp end");
      chk(vblank_start, {sh[9][5], sh[7][3], 8'h00}, "blank");
      chk(line_cmp_hi, {sh[9][6], sh[7][4], 8'h00}, "compare");
      chk(line_double, sh[9][7], "double");
      chk({byte_pan, pan_pixels}, {sh[8][6:5], sh[8][6:5], 3'b000}, "pan");
      chk(screen_base, {sh[12], sh[13]}, "base");
      chk(cursor_addr, {sh[14], sh[15]}, "cursor addr");
    end
    vcr_host_model_i.wr(8'h10, 8'h5a);
    vcr_host_model_i.rd(8'h10, got);
    chk(got, 8'h00, "unmapped");
    vcr_host_model_i.rd_idx(got);
    chk(got, 8'h10, "index");
    row_test(5'h03, 5'h07, 10);
    // Enable low: every strobe is ignored and all state holds
    @(posedge ref_clk);
    clk_en <= 1'b0;
    vcr_host_model_i.wr(8'h0c, ~sh[12]);
    vcr_host_model_i.rd(8'h09, got);
    pulse(3'b010);
    pulse(3'b100);
    chk(screen_base, {sh[12], sh[13]}, "frozen base");
    chk(got, 8'h10, "frozen read");
    chk(row_scan, 5'h05, "frozen row");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    row_test(5'h00, 5'h00, 3);
    row_test(5'h1e, 5'h1f, 4);
    m = 5'($urandom);
    row_test(5'($urandom % (m + 1)), m, 40);
    ca = 16'($urandom);
    put(8'h0e, ca[15:8]);
    put(8'h0f, ca[7:0]);
    cur(8'h04, 5'h06, 5'h04, 1'b1);
    cur(8'h04, 5'h06, 5'h06, 1'b1);
    cur(8'h04, 5'h06, 5'h07, 1'b1);
    cur(8'h24, 5'h06, 5'h05, 1'b1);
    cur(8'h07, 5'h03, 5'h05, 1'b1);
    cur(8'h02, 5'h04, 5'h03, 1'b0);
    repeat (8) cur(8'($urandom), 5'($urandom), 5'($urandom), 1'($urandom));
    cur(8'h00, 5'h1f, 5'h00, 1'b1);
    put(8'h0b, 8'h5f);
    repeat (3) pulse(3'b001);
    chk(cursor_out, 1'b1, "skew fill");
    @(posedge ref_clk);
    char_addr <= ~ca;
    pulse(3'b001);
    chk(cursor_out, 1'b1, "skew hold");
    pulse(3'b001);
    chk(cursor_out, 1'b0, "skew drop");
    // Skew settings 1 to 3: a cursor edge appears after exactly that many ticks
    for (int k = 1; k < 4; k++) begin
      @(posedge ref_clk);
      char_addr <= ~ca;
      repeat (3) pulse(3'b001);
      put(8'h0b, {1'b0, 2'(k), 5'h1f});
      @(posedge ref_clk);
      char_addr <= ca;
      @(posedge ref_clk);
      #1;
      chk(cursor_out, 1'b0, "skew lead");
      for (int t = 1; t < 4; t++) begin
        pulse(3'b001);
        chk(cursor_out, 1'(t >= k), "skew step");
      end
    end
    // Reset in mid-run clears registers, index, read data and row counter
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk({screen_base, cursor_addr}, 32'h0000_0000, "mid reset regs");
    chk({rdata, row_scan, vert_total}, 32'h0000_0000, "mid reset state");
    vcr_host_model_i.rd_idx(got);
    chk(got, 8'h00, "mid reset index");
    complete_run();
  end

  // Watchdog against a hung run
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule // vcr_regs_tb

// ### verilog/vcr_defs.svh
// Register indices, field positions and reset values for the vertical/cursor register set
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH
`define VCR_IDX_VTOTAL 6'h06
`define VCR_IDX_OVFL 6'h07
`define VCR_IDX_PRESET 6'h08
`define VCR_IDX_MAXSL 6'h09
`define VCR_IDX_CSTART 6'h0a
`define VCR_IDX_CEND 6'h0b
`define VCR_IDX_BASE_HI 6'h0c
`define VCR_IDX_BASE_LO 6'h0d
`define VCR_IDX_CPOS_HI 6'h0e
`define VCR_IDX_CPOS_LO 6'h0f
`define VCR_REG_RESET 8'h00
`define VCR_VT_BIAS 10'h002
`define VCR_OV_VT8 0
`define VCR_OV_VDE8 1
`define VCR_OV_VSS8 2
`define VCR_OV_VBS8 3
`define VCR_OV_LC8 4
`define VCR_OV_VT9 5
`define VCR_OV_VDE9 6
`define VCR_OV_VSS9 7
`define VCR_MS_DOUBLE 7
`define VCR_MS_LC9 6
`define VCR_MS_VBS9 5
`define VCR_CS_OFF 5
`define VCR_PRESET_MASK 8'h7f
`define VCR_CSTART_MASK 8'h3f
`define VCR_CEND_MASK 8'h7f
`endif

// ### verilog/vcr_pkg.sv
// Types shared by the vertical/cursor register block
package vcr_pkg;
  typedef enum logic [1:0] {
    VCR_PAN_0 = 2'b00,
    VCR_PAN_8 = 2'b01,
    VCR_PAN_16 = 2'b10,
    VCR_PAN_24 = 2'b11
  } vcr_pan_t;
endpackage

// ### verilog/vcr_regs.sv
// Vertical timing overflow, row scan and text cursor registers
//
// Overview of operation
// R1: Vertical total is ten bits, scan lines per frame minus two, low byte 0x6.
// R2: Total bit 8 from overflow bit 0, bit 9 from overflow bit 5.
// R3: Overflow bits 7,2 feed sync start 9,8; bits 6,1 display end 9,8.
// R4: Overflow bit 4 feeds line compare bit 8; bit 3 vertical blank start 8.
// R5: Row scan counter loads the preset field once after each vertical retrace.
// R6: Row scan counter steps per horizontal retrace, clears at maximum scan line.
// R7: Byte panning code 0..3 shifts the display left 0, 8, 16, 24 pixels.
// R8: Maximum scan line bit 7 set selects line doubling.
// R9: Maximum scan line field is lines per row minus one, row counter terminal.
// R10: Max scan bit 6 feeds line compare bit 9; bit 5 vertical blank start 9.
// R11: Cursor start bit 5 low enables cursor, high suppresses it.
// R12: Cursor begins at start row; start above end yields no cursor.
// R13: Cursor active through end row inclusive; end below start shows none.
// R14: Cursor skew delays cursor right by that many character clocks.
// R15: Sixteen-bit screen start address, high byte 0xC, low byte 0xD.
// R16: Sixteen-bit cursor address, high byte 0xE, low byte 0xF.
// R17: Cursor start bits 7:6 read back zero.
// R18: Software writes the index port first, then accesses the data port.
// R19: Cursor drawn where address matches location and row lies in range.
`timescale 1ns/1ps
`include "vcr_defs.svh"
module vcr_regs #(
  parameter int SKEW_DEPTH = 3
) (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic idx_wr, // Index port write strobe
  input wire logic idx_rd, // Index port read strobe
  input wire logic data_wr, // Data port write strobe
  input wire logic data_rd, // Data port read strobe
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata, // Read data, registered
  input wire logic char_tick, // Character clock strobe
  input wire logic hretrace_end, // Pulse at end of horizontal retrace
  input wire logic vretrace_end, // Pulse at end of vertical retrace
  input wire logic [15:0] char_addr, // Memory address of current character
  output logic [9:0] vert_total, // Scan lines per frame minus two
  output logic [9:0] vsync_start, // Vertical sync start
  output logic [9:0] vde_end, // Vertical display end
  output logic [9:0] vblank_start, // Vertical blank start
  output logic [9:0] line_cmp_hi, // Line compare bits 9:8 (low byte zero)
  output logic line_double, // Line doubling select
  output vcr_pkg::vcr_pan_t byte_pan, // Byte panning code
  output logic [4:0] pan_pixels, // Left shift in pixels
  output logic [4:0] row_scan, // Row scan counter
  output logic [15:0] screen_base, // Refresh start address
  output logic [15:0] cursor_addr, // Cursor location
  output logic cursor_out // Skewed cursor active
);
  logic [5:0] index_q;
  logic [7:0] vtotal_q, ovfl_q, preset_q, maxsl_q, cstart_q, cend_q;
  logic [7:0] base_hi_q, base_lo_q, cpos_hi_q, cpos_lo_q;
  logic [4:0] row_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic row_at_max, cursor_raw, cursor_window;
  logic wr_any;

  // ----------------------------------------
  // Index port
  // ----------------------------------------
  // Data port always targets whatever the last index write selected
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q <= '0;
    end else if (clk_en && idx_wr) begin
      index_q <= wdata[5:0]; // R18
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  assign wr_any = clk_en && data_wr;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vtotal_q <= `VCR_REG_RESET;
      ovfl_q <= `VCR_REG_RESET;
      preset_q <= `VCR_REG_RESET;
      maxsl_q <= `VCR_REG_RESET;
      cstart_q <= `VCR_REG_RESET;
      cend_q <= `VCR_REG_RESET;
      base_hi_q <= `VCR_REG_RESET;
      base_lo_q <= `VCR_REG_RESET;
      cpos_hi_q <= `VCR_REG_RESET;
      cpos_lo_q <= `VCR_REG_RESET;
    end else if (wr_any) begin
      unique case (index_q)
        `VCR_IDX_VTOTAL: vtotal_q <= wdata; // R1
        `VCR_IDX_OVFL: ovfl_q <= wdata; // R2
        `VCR_IDX_PRESET: preset_q <= wdata & `VCR_PRESET_MASK;
        `VCR_IDX_MAXSL: maxsl_q <= wdata;
        `VCR_IDX_CSTART: cstart_q <= wdata & `VCR_CSTART_MASK; // R17
        `VCR_IDX_CEND: cend_q <= wdata & `VCR_CEND_MASK;
        `VCR_IDX_BASE_HI: base_hi_q <= wdata; // R15
        `VCR_IDX_BASE_LO: base_lo_q <= wdata; // R15
        `VCR_IDX_CPOS_HI: cpos_hi_q <= wdata; // R16
        `VCR_IDX_CPOS_LO: cpos_lo_q <= wdata; // R16
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Indices outside this set read zero; other blocks answer them
  assign rd_mux = (index_q == `VCR_IDX_VTOTAL) ? vtotal_q :
                  (index_q == `VCR_IDX_OVFL) ? ovfl_q :
                  (index_q == `VCR_IDX_PRESET) ? preset_q :
                  (index_q == `VCR_IDX_MAXSL) ? maxsl_q :
                  (index_q == `VCR_IDX_CSTART) ? cstart_q :
                  (index_q == `VCR_IDX_CEND) ? cend_q :
                  (index_q == `VCR_IDX_BASE_HI) ? base_hi_q :
                  (index_q == `VCR_IDX_BASE_LO) ? base_lo_q :
                  (index_q == `VCR_IDX_CPOS_HI) ? cpos_hi_q :
                  (index_q == `VCR_IDX_CPOS_LO) ? cpos_lo_q : 8'h00;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en && idx_rd) begin
      rdata_q <= {2'b00, index_q};
    end else if (clk_en && data_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign rdata = rdata_q;

  // ----------------------------------------
  // Assembled vertical values
  // ----------------------------------------
  assign vert_total = {ovfl_q[`VCR_OV_VT9], ovfl_q[`VCR_OV_VT8], vtotal_q}; // R1 R2
  assign vsync_start = {ovfl_q[`VCR_OV_VSS9], ovfl_q[`VCR_OV_VSS8], 8'h00}; // R3
  assign vde_end = {ovfl_q[`VCR_OV_VDE9], ovfl_q[`VCR_OV_VDE8], 8'h00}; // R3
  // Low bytes of these live in registers outside this block
  assign line_cmp_hi = {maxsl_q[`VCR_MS_LC9], ovfl_q[`VCR_OV_LC8], 8'h00}; // R4 R10
  assign vblank_start = {maxsl_q[`VCR_MS_VBS9], ovfl_q[`VCR_OV_VBS8], 8'h00}; // R4 R10
  assign line_double = maxsl_q[`VCR_MS_DOUBLE]; // R8
  assign byte_pan = vcr_pkg::vcr_pan_t'(preset_q[6:5]); // R7
  assign pan_pixels = {preset_q[6:5], 3'b000}; // R7
  assign screen_base = {base_hi_q, base_lo_q}; // R15
  assign cursor_addr = {cpos_hi_q, cpos_lo_q}; // R16

  // ----------------------------------------
  // Row scan counter
  // ----------------------------------------
  assign row_at_max = (row_q == maxsl_q[4:0]); // R9
  // Vertical retrace preset wins over a coincident horizontal step
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      row_q <= 5'h00;
    end else if (clk_en) begin
      if (vretrace_end) begin
        row_q <= preset_q[4:0]; // R5
      end else if (hretrace_end) begin
        row_q <= row_at_max ? 5'h00 : row_q + 5'h01; // R6
      end
    end
  end
  assign row_scan = row_q;

  // ----------------------------------------
  // Cursor
  // ----------------------------------------
  // Start > end makes the window empty on its own, no extra compare needed
  assign cursor_window = (row_q >= cstart_q[4:0]) && (row_q <= cend_q[4:0]); // R12 R13
  assign cursor_raw = !cstart_q[`VCR_CS_OFF] && cursor_window && // R11
                      (char_addr == cursor_addr); // R19

  vcr_skew_delay #(.DEPTH(SKEW_DEPTH)) u_skew (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .char_tick(char_tick),
    .din(cursor_raw),
    .skew(cend_q[6:5]),
    .dout(cursor_out)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_vret;
    clk_en && vretrace_end;
  endsequence

  AST_PRESET: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    s_vret |=> row_scan == $past(preset_q[4:0]))
    else $error("row scan not preset after vertical retrace");
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    clk_en && !vretrace_end && hretrace_end && row_at_max |=> row_scan == 5'h00)
    else $error("row scan did not clear at maximum");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
    clk_en && !vretrace_end && hretrace_end && !row_at_max |=>
    row_scan == $past(row_scan) + 5'h01)
    else $error("row scan did not step");
  AST_RSV: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
    cstart_q[7:6] == 2'b00)
    else $error("cursor start reserved bits nonzero");
  AST_VT: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    vert_total[9] == ovfl_q[5] && vert_total[8] == ovfl_q[0])
    else $error("vertical total overflow bits wrong");
  AST_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
    cstart_q[5] |-> !cursor_raw)
    else $error("cursor drawn while suppressed");
  AST_EMPTY: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
    cstart_q[4:0] > cend_q[4:0] |-> !cursor_raw)
    else $error("cursor drawn with start above end");
  AST_SKEW0: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    cend_q[6:5] == 2'b00 |-> cursor_out == cursor_raw)
    else $error("unskewed cursor delayed");
  AST_WR: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
    clk_en && data_wr && index_q == `VCR_IDX_BASE_LO |=>
    screen_base[7:0] == $past(wdata))
    else $error("start address low not written");

  // ----------------------------------------
  // Field routing
  // ----------------------------------------
  // Pure wiring, yet a swapped overflow bit shows here long before it shows on screen
  AST_VT_LO: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    vert_total[7:0] == vtotal_q)
    else $error("vertical total low byte wrong");
  AST_VSS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    vsync_start[9:8] == {ovfl_q[`VCR_OV_VSS9], ovfl_q[`VCR_OV_VSS8]})
    else $error("sync start overflow bits wrong");
  AST_VDE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    vde_end[9:8] == {ovfl_q[`VCR_OV_VDE9], ovfl_q[`VCR_OV_VDE8]})
    else $error("display end overflow bits wrong");
  AST_BIT8: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    line_cmp_hi[8] == ovfl_q[`VCR_OV_LC8] && vblank_start[8] == ovfl_q[`VCR_OV_VBS8])
    else $error("compare or blank bit 8 wrong");
  AST_BIT9: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
    line_cmp_hi[9] == maxsl_q[`VCR_MS_LC9] && vblank_start[9] == maxsl_q[`VCR_MS_VBS9])
    else $error("compare or blank bit 9 wrong");
  AST_DBL: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
    line_double == maxsl_q[`VCR_MS_DOUBLE])
    else $error("line doubling select wrong");
  AST_PAN: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    pan_pixels == {byte_pan, 3'b000})
    else $error("pan pixels not eight per byte");

  // ----------------------------------------
  // Cursor shape and location
  // ----------------------------------------
  // The window and the address compare must gate the cursor in both directions
  AST_CUR_ON: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
    !cstart_q[`VCR_CS_OFF] && cursor_window && char_addr == cursor_addr |-> cursor_raw)
    else $error("cursor missing at its location");
  AST_PRE_START: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
    row_q < cstart_q[4:0] |-> !cursor_raw)
    else $error("cursor drawn above its first line");
  AST_PAST_END: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    row_q > cend_q[4:0] |-> !cursor_raw)
    else $error("cursor drawn below its last line");
  AST_RD_RSV: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
    clk_en && data_rd && !idx_rd && index_q == `VCR_IDX_CSTART |=>
    rdata[7:6] == 2'b00)
    else $error("cursor start reserved bits read nonzero");
  AST_BASE_HI: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
    clk_en && data_wr && index_q == `VCR_IDX_BASE_HI |=>
    screen_base[15:8] == $past(wdata))
    else $error("start address high not written");
  sequence s_cpos_hi_wr;
    clk_en && data_wr && index_q == `VCR_IDX_CPOS_HI;
  endsequence
  AST_CPOS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R16
    s_cpos_hi_wr |=> cursor_addr[15:8] == $past(wdata))
    else $error("cursor location high not written");

  // ----------------------------------------
  // Multi-step checks
  // ----------------------------------------
  // Skew is only judged when it stays put across the tick under test
  sequence s_tick_skew1;
    clk_en && char_tick && cend_q[6:5] == 2'b01;
  endsequence
  sequence s_skew1_kept;
    cend_q[6:5] == 2'b01;
  endsequence
  AST_SKEW1: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    s_tick_skew1 ##1 s_skew1_kept |-> cursor_out == $past(cursor_raw))
    else $error("one-clock skew did not delay by one tick");
  // A preset followed by one step proves the preset really fed the counter
  sequence s_preset_then_step;
    clk_en && vretrace_end ##1 !vretrace_end && !hretrace_end ##1
    clk_en && !vretrace_end && hretrace_end && !row_at_max;
  endsequence
  AST_PRESET_STEP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    s_preset_then_step |=> row_scan == $past(preset_q[4:0], 3) + 5'h01)
    else $error("row scan did not step from the preset");
  // Enable low must freeze counters, index and read data alike
  sequence s_frozen;
    !clk_en;
  endsequence
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    s_frozen |=> $stable(row_scan) && $stable(rdata) && $stable(index_q) &&
    $stable(screen_base))
    else $error("state moved while the clock enable was low");
endmodule // vcr_regs

// ### verilog/vcr_skew_delay.sv
// Character-clock delay line for the cursor, tap chosen by skew
`timescale 1ns/1ps
module vcr_skew_delay #(
  parameter int DEPTH = 3
) (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Async reset
  input wire logic clk_en, // Clock enable
  input wire logic char_tick, // Character clock strobe
  input wire logic din, // Undelayed cursor
  input wire logic [1:0] skew, // Delay in character clocks
  output logic dout // Delayed cursor
);
  logic [DEPTH-1:0] tap_q;
  logic [DEPTH:0] taps;

  // ----------------------------------------
  // Shift register, one stage per character
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_q <= '0;
    end else if (clk_en && char_tick) begin
      tap_q <= {tap_q[DEPTH-2:0], din};
    end
  end

  assign taps = {tap_q, din};
  // Skew 0 passes straight through so an unskewed cursor adds no latency
  assign dout = taps[skew]; // R14
endmodule // vcr_skew_delay
